// >>> adcsq_consts.vh
// constants for the channel sequencer block
`ifndef ADCSQ_CONSTS_VH
`define ADCSQ_CONSTS_VH

// ----------------------------------------
// frame layout
// ----------------------------------------
`define ADCSQ_FRAME_BITS 16
`define ADCSQ_ADDR_MSB 15
`define ADCSQ_ADDR_LSB 9
`define ADCSQ_RD_BIT 8

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADCSQ_OFS_MANUAL 7'h04
`define ADCSQ_OFS_AUTO 7'h05
`define ADCSQ_OFS_MASK 7'h0c
`define ADCSQ_OFS_PAGE 7'h7f

// ----------------------------------------
// field positions
// ----------------------------------------
`define ADCSQ_RESTART_BIT 7
`define ADCSQ_CHAN_MSB 6
`define ADCSQ_CHAN_LSB 5
`define ADCSQ_RANGE_MSB 3
`define ADCSQ_RANGE_LSB 1
`define ADCSQ_TEMP_BIT 0
`define ADCSQ_PAGE_BIT 0

// ----------------------------------------
// codes and reset values
// ----------------------------------------
`define ADCSQ_RANGE_CFG 3'h0
`define ADCSQ_RANGE_PD 3'h7
`define ADCSQ_PAGE_ONE 8'h01
`define ADCSQ_RST_MANUAL 8'h00
`define ADCSQ_RST_AUTO 8'h00
`define ADCSQ_RST_MASK 8'h00
`define ADCSQ_RST_PAGE 1'h0

`endif

// >>> adcsq_sequencer.v
// channel sequencing control with serial register access
`timescale 1ns/1ps
`default_nettype none
`include "adcsq_consts.vh"

module adcsq_sequencer #(
  parameter NUM_CH = 4
) (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // serial link pins
  input wire sclk,
  input wire cs_n,
  input wire din,
  output reg dout,
  // conversion control for the frame now running
  output reg [1:0] acq_channel,
  output reg acq_temp,
  output reg [2:0] acq_range,
  output reg power_down,
  // conversion whose result is shifted in this frame
  output reg [1:0] res_channel,
  output reg res_temp,
  output reg res_valid,
  // status
  output reg auto_mode,
  output reg page_sel,
  output reg frame_end
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function [3:0] chan_mask;
    input [7:0] r;
    begin
      chan_mask = {r[1], r[3], r[5], r[7]};
    end
  endfunction

  function [1:0] lowest_chan;
    input [3:0] m;
    integer i;
    begin
      lowest_chan = 2'h0;
      for (i = NUM_CH - 1; i >= 0; i = i - 1) begin
        if (m[i]) begin
          lowest_chan = i[1:0];
        end
      end
    end
  endfunction

  function [1:0] next_chan;
    input [3:0] m;
    input [1:0] cur;
    integer i;
    reg found;
    begin
      next_chan = lowest_chan(m);
      found = 1'b0;
      for (i = 0; i < NUM_CH; i = i + 1) begin
        if (!found && m[i] && i[1:0] > cur) begin
          next_chan = i[1:0];
          found = 1'b1;
        end
      end
    end
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  reg sclk_s1;
  reg sclk_s2;
  reg sclk_s3;
  reg cs_s1;
  reg cs_s2;
  reg cs_s3;
  reg din_s1;
  reg din_s2;

  always @(posedge sys_clk) begin
    if (rst) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      din_s1 <= 1'b0;
      din_s2 <= 1'b0;
    end else begin
      sclk_s1 <= sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      din_s1 <= din;
      din_s2 <= din_s1;
    end
  end

  wire sclk_fall = sclk_s3 & ~sclk_s2 & ~cs_s2;
  wire cs_start = cs_s3 & ~cs_s2;

  // ----------------------------------------
  // registers and frame state
  // ----------------------------------------
  reg [7:0] manual_sequence_control;
  reg [7:0] auto_scan_control;
  reg [7:0] scan_set_mask;
  reg [14:0] rx_shift;
  reg [15:0] tx_shift;
  reg [15:0] tx_next;
  reg [4:0] bit_cnt;
  reg [1:0] scan_pos;

  wire [15:0] word = {rx_shift, din_s2};
  wire [6:0] addr = word[`ADCSQ_ADDR_MSB:`ADCSQ_ADDR_LSB];
  wire is_read = word[`ADCSQ_RD_BIT];
  wire [7:0] wdata = word[7:0];
  wire last_bit = sclk_fall && (bit_cnt == 5'h0f);
  wire on_page0 = (page_sel == 1'b0);
  wire wr_manual = !is_read && on_page0 && (addr == `ADCSQ_OFS_MANUAL);
  wire wr_auto = !is_read && on_page0 && (addr == `ADCSQ_OFS_AUTO);
  wire wr_mask = !is_read && on_page0 && (addr == `ADCSQ_OFS_MASK);
  wire wr_page = !is_read && (addr == `ADCSQ_OFS_PAGE);
  wire [2:0] wr_range = wdata[`ADCSQ_RANGE_MSB:`ADCSQ_RANGE_LSB];
  wire [3:0] mask4 = chan_mask(scan_set_mask);

  // ----------------------------------------
  // fields of the frame being committed
  // ----------------------------------------
  wire wr_temp = wdata[`ADCSQ_TEMP_BIT];
  wire wr_restart = wdata[`ADCSQ_RESTART_BIT];
  wire wr_pd = (wr_range == `ADCSQ_RANGE_PD);
  wire wr_override = !wr_temp && !wr_pd;
  wire [1:0] wr_pick = wdata[`ADCSQ_CHAN_MSB:`ADCSQ_CHAN_LSB];
  wire [1:0] scan_first = lowest_chan(mask4);
  wire [1:0] scan_step = next_chan(mask4, scan_pos);

  // ----------------------------------------
  // read data for the following frame
  // ----------------------------------------
  always @* begin
    tx_next = 16'h0000;
    if (is_read) begin
      case (addr)
        `ADCSQ_OFS_MANUAL: tx_next[15:8] = on_page0 ? manual_sequence_control : 8'h00;
        `ADCSQ_OFS_AUTO: tx_next[15:8] = on_page0 ? auto_scan_control : 8'h00;
        `ADCSQ_OFS_MASK: tx_next[15:8] = on_page0 ? scan_set_mask : 8'h00;
        `ADCSQ_OFS_PAGE: tx_next[15:8] = {7'h00, page_sel};
        default: tx_next = 16'h0000;
      endcase
    end
  end

  // ----------------------------------------
  // serial shift and frame counting
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      rx_shift <= 15'h0000;
      tx_shift <= 16'h0000;
      bit_cnt <= 5'h00;
      dout <= 1'b0;
      frame_end <= 1'b0;
    end else begin
      frame_end <= 1'b0;
      if (cs_start) begin
        bit_cnt <= 5'h00;
        dout <= tx_shift[15];
      end else if (sclk_fall) begin
        rx_shift <= {rx_shift[13:0], din_s2};
        if (last_bit) begin
          bit_cnt <= 5'h00;
          tx_shift <= tx_next;
          dout <= tx_next[15];
          frame_end <= 1'b1;
        end else begin
          bit_cnt <= bit_cnt + 5'h01;
          tx_shift <= {tx_shift[14:0], 1'b0};
          dout <= tx_shift[14];
        end
      end
    end
  end

  // ----------------------------------------
  // register writes at frame end
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      page_sel <= `ADCSQ_RST_PAGE;
      manual_sequence_control <= `ADCSQ_RST_MANUAL;
      auto_scan_control <= `ADCSQ_RST_AUTO;
      scan_set_mask <= `ADCSQ_RST_MASK;
    end else if (last_bit) begin
      if (wr_page) begin
        page_sel <= (wdata == `ADCSQ_PAGE_ONE);
      end
      if (wr_manual) begin
        manual_sequence_control <= wdata;
      end
      if (wr_auto) begin
        auto_scan_control <= wdata;
      end
      if (wr_mask) begin
        scan_set_mask <= wdata;
      end
    end
  end

  // ----------------------------------------
  // sequencing decision for the next frame
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      auto_mode <= 1'b0;
      acq_channel <= 2'h0;
      acq_temp <= 1'b0;
      acq_range <= `ADCSQ_RANGE_CFG;
      power_down <= 1'b0;
      scan_pos <= 2'h0;
    end else if (last_bit) begin
      // override lasts one frame only
      acq_range <= `ADCSQ_RANGE_CFG;
      if (wr_manual) begin
        auto_mode <= 1'b0;
        power_down <= wr_pd;
        acq_temp <= wr_temp;
        acq_channel <= wr_pick;
        if (wr_override) begin
          acq_range <= wr_range;
        end
      end else if (wr_auto) begin
        auto_mode <= 1'b1;
        power_down <= wr_pd;
        acq_temp <= wr_temp;
        // restart wins over temp
        if (wr_restart) begin
          scan_pos <= scan_first;
          acq_channel <= scan_first;
          acq_temp <= 1'b0;
        end else if (wr_temp) begin
          scan_pos <= scan_pos;
        end else begin
          scan_pos <= scan_step;
          acq_channel <= scan_step;
        end
        if (wr_override) begin
          acq_range <= wr_range;
        end
      end else begin
        // any other frame keeps the mode and temp choice
        if (auto_mode && !acq_temp) begin
          scan_pos <= scan_step;
          acq_channel <= scan_step;
        end
      end
    end
  end

  // ----------------------------------------
  // result bookkeeping, one frame behind
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (rst) begin
      res_channel <= 2'h0;
      res_temp <= 1'b0;
      res_valid <= 1'b0;
    end else if (last_bit) begin
      // frame n+1 result carries what frame n sampled
      res_channel <= acq_channel;
      res_temp <= acq_temp;
      res_valid <= ~power_down;
    end
  end

endmodule
`default_nettype wire

// >>> adcsq_asserts.sv
// assertion checker for the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module adcsq_asserts (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // observed ports
  input wire logic cs_n,
  input wire logic [1:0] acq_channel,
  input wire logic acq_temp,
  input wire logic [2:0] acq_range,
  input wire logic power_down,
  input wire logic [1:0] res_channel,
  input wire logic res_temp,
  input wire logic auto_mode,
  input wire logic page_sel,
  input wire logic frame_end
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  chk_reset_page: assert property ($fell(rst) |-> !page_sel)
    else $error("page after reset");
  chk_reset_ctrl: assert property ($fell(rst) |-> !auto_mode && !power_down)
    else $error("mode after reset");
  chk_frame_gap: assert property (frame_end |=> !frame_end [*8])
    else $error("commit pulse");
  chk_commit_only: assert property (
    $changed({acq_channel, acq_temp, acq_range, auto_mode, page_sel}) |-> frame_end)
    else $error("change off commit");
  chk_result_lag: assert property (
    frame_end |-> res_channel == $past(acq_channel) && res_temp == $past(acq_temp))
    else $error("result lag");
  chk_temp_range: assert property (acq_temp |-> acq_range == 3'h0)
    else $error("temp range");
  chk_pd_commit: assert property ($changed(power_down) |-> frame_end)
    else $error("power change");
  chk_cs_frame: assert property (frame_end |-> !$past(cs_n, 4))
    else $error("commit outside frame");
  cover property (frame_end && auto_mode);
  cover property (frame_end && acq_temp);
  cover property ($rose(power_down));
endmodule
bind adcsq_sequencer adcsq_asserts u_chk (.sys_clk, .rst, .cs_n, .acq_channel, .acq_temp,
  .acq_range, .power_down, .res_channel, .res_temp, .auto_mode, .page_sel, .frame_end);
`default_nettype wire

// >>> adcsq_host.sv
// serial host model driving 16-bit frames
`timescale 1ns/1ps
`default_nettype none
module adcsq_host (
  // clock
  input wire logic sys_clk,
  // link
  output logic sclk = 0,
  output logic cs_n = 1,
  output logic din = 0,
  input wire logic dout
);
  // msb first, 64 ns period, clock still between frames
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    r = 16'h0;
    @(posedge sys_clk);
    cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      din <= w[i];
      repeat (4) @(posedge sys_clk);
      sclk <= 1'b1;
      repeat (8) @(posedge sys_clk);
      r = {r[14:0], dout};
      sclk <= 1'b0;
      repeat (4) @(posedge sys_clk);
    end
    repeat (6) @(posedge sys_clk);
    cs_n <= 1'b1;
    din <= ~w[0];
    repeat (8) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// >>> tb.sv
// self-checking bench for the channel sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module tb;
  logic sys_clk = 0, rst = 1, sclk, cs_n, din, dout, acq_temp, power_down, res_temp;
  logic auto_mode, page_sel, frame_end, pg, am, tp, pd, pt, pok, rv, wt, res_valid;
  logic [1:0] acq_channel, res_channel, ch, pc, sp;
  logic [2:0] acq_range, ov;
  logic [7:0] mk, d, mr, ar;
  logic [15:0] rd, ex, q[$];
  int failures = 0, total_checks = 0, k;
  integer seed = 56;
  adcsq_sequencer uut (.sys_clk, .rst, .sclk, .cs_n, .din, .dout, .acq_channel, .acq_temp,
    .acq_range, .power_down, .res_channel, .res_temp, .res_valid, .auto_mode, .page_sel,
    .frame_end);
  adcsq_host host (.sys_clk, .sclk, .cs_n, .din, .dout);
  function automatic logic [1:0] nxt(logic [7:0] m, logic [1:0] c);
    for (int j = 1; j <= 4; j++) begin
      if (m[7 - 2 * ((c + j) % 4)]) return 2'(c + j);
    end
    return 2'h0;
  endfunction
  function automatic logic [15:0] wr(logic [6:0] a, logic [7:0] v);
    return {a, 1'b0, v};
  endfunction
  task automatic reset_all;
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    {pg, am, tp, pd, rv, ch, ov, mk, sp, mr, ar} = '0;
  endtask
  task automatic frame(input logic [15:0] w);
    wt = !w[8] && !pg;
    d = w[7:0];
    host.xfer(w, rd);
    if (rv) `CHK(rd, ex)
    rv = w[8];
    case (w[15:9])
      7'h04: ex = {pg ? 8'h00 : mr, 8'h00};
      7'h05: ex = {pg ? 8'h00 : ar, 8'h00};
      7'h0c: ex = {pg ? 8'h00 : mk, 8'h00};
      7'h7f: ex = {7'h00, pg, 8'h00};
      default: ex = 16'h0000;
    endcase
    {pc, pt, pok, ov} = {ch, tp, !pd, 3'h0};
    if (wt && w[15:9] == 7'h04) begin
      mr = d;
      {am, ov, tp} = {1'b0, d[3:0]};
      pd = ov == 3'h7;
      if (!tp) ch = d[6:5];
    end else if (wt && w[15:9] == 7'h05) begin
      ar = d;
      {am, ov} = {1'b1, d[3:1]};
      pd = ov == 3'h7;
      if (d[7]) sp = nxt(mk, 2'h3);
      else if (!d[0]) sp = nxt(mk, sp);
      if (d[7] || !d[0]) ch = sp;
      tp = d[0] && !d[7];
    end else begin
      if (wt && w[15:9] == 7'h0c) mk = d;
      if (!w[8] && w[15:9] == 7'h7f) pg = d == 8'h01;
      if (am && !tp) begin
        sp = nxt(mk, sp);
        ch = sp;
      end
    end
    `CHK(page_sel, pg)
    `CHK(auto_mode, am)
    `CHK(power_down, pd)
    `CHK(res_valid, pok)
    if (!pd) begin
      `CHK(acq_temp, tp)
      `CHK(acq_range, tp ? 3'h0 : ov)
      if (!tp) `CHK(acq_channel, ch)
      if (pok) `CHK(res_temp, pt)
      if (pok && !pt) `CHK(res_channel, pc)
    end
  endtask
  task automatic run(input string name);
    while (q.size() > 0) frame(q.pop_front());
    $display("test %s done", name);
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial forever #2 sys_clk = ~sys_clk;
  initial begin
    #200000;
    failures++;
    $display("watchdog expired");
    wrap_up();
  end
  initial begin
    reset_all();
    for (k = 0; k < 7; k++) begin
      if (k != 4) q.push_back(wr(7'h04, {1'b0, 2'(k + 1), 1'b0, 3'(k), 1'b0}));
    end
    q = {q, 16'h0, wr(7'h04, 8'h41), 16'h0, wr(7'h04, 8'h0e), 16'h0, wr(7'h04, 8'h60)};
    run("manual");
    q = {16'h0900, 16'hff00, 16'h0, wr(7'h7f, 8'h01), 16'h0900, 16'hff00, 16'h0,
      wr(7'h04, 8'h20)};
    run("page");
    reset_all();
    q = {16'hff00, 16'h0};
    run("reset");
    q = {wr(7'h0c, 8'h8a), wr(7'h04, 8'h60), wr(7'h05, 8'h00), 16'h0, 16'h0, 16'h0,
      wr(7'h05, 8'h01), wr(7'h05, 8'h00), 16'h0, 16'h0, wr(7'h05, 8'h80), wr(7'h05, 8'h04),
      wr(7'h05, 8'h0e), 16'h0, wr(7'h04, 8'h00), wr(7'h0c, 8'h00), wr(7'h05, 8'h00), 16'h0};
    run("auto");
    q = {wr(7'h04, 8'h00), wr(7'h0c, 8'ha8)};
    repeat (24) begin
      k = {$random(seed)} % 3;
      d = 8'($random(seed));
      if (d[3:1] == 3'h4 || d[3:1] == 3'h7) d[3] = 1'b0;
      q.push_back(k == 0 ? 16'h0 : wr(k == 1 ? 7'h04 : 7'h05, d & (k == 1 ? 8'h7f : 8'h8e)));
    end
    q = {q, 16'h0900, 16'h0b00, 16'h1900, 16'h0};
    run("random");
    wrap_up();
  end
endmodule
`default_nettype wire
